// ### rtl/fpkl_top.sv
// Purpose: Front panel key decoding and LED drive
// Assumes: Keys are debounced levels from pins; status from sys_clk logic
// Notes:   Wishbone classic slave, ack one cycle after request is seen
//
// How it works
// - Normal key: normal mode, else check report
// - Dial key seizes line; hold talks
// - Arm key toggles arm_toggle_key clears alarms
// - Power key toggles unit on and off
// - Program enters mode; enter executes; cancel discards
// - Record only while held and enabled
// - Any key acknowledges all pending alarms
// - Normal and check LEDs follow mode
// - Low battery LED follows threshold input
// - Power fail lit; lit LEDs blink fast
// - Telephone failure LED fast blinks unacked
// - PLC net LED scan and comm alarm
// - Printer LED enable and flow control
// - Log LED enable and data loss
// - Program LED for any program source
// - Recording LED exactly while recording
// - Disarmed LED blinks while disarmed
// - Line_activity_indicator LED steady, slow blink, off
// - Channel LEDs blink unacked alarmed, share phase
// - Dial while connected suspends report, no dial
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "fpkl_map.svh"

module fpkl_top #(
  parameter int NCHAN = 8
) (
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire logic                 clk_en,
  input  wire logic [`FPKL_NKEYS-1:0] key_pins,
  input  wire logic                 digit_pin,
  input  wire fpkl_pkg::fpkl_status_t status_in,
  input  wire logic [NCHAN-1:0]     chan_alarm,
  input  wire logic [NCHAN-1:0]     chan_acked,
  input  wire logic                 alarm_unacked,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  output fpkl_pkg::fpkl_leds_t      leds_o,
  output logic [NCHAN-1:0]          chan_led_o,
  output fpkl_pkg::fpkl_cmd_t       cmd_o,
  output logic                      unit_on_o,
  output logic                      disarmed_o,
  output logic                      recording_o,
  output fpkl_pkg::fpkl_mode_t      mode_o
);

  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic [`FPKL_NKEYS-1:0] key_s1_ff;
  logic [`FPKL_NKEYS-1:0] key_s2_ff;
  logic [`FPKL_NKEYS-1:0] key_d_ff;
  logic [2:0]             dig_ff;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      key_s1_ff <= '0;
      key_s2_ff <= '0;
      key_d_ff  <= '0;
      dig_ff    <= 3'h0;
    end else if (clk_en) begin
      key_s1_ff <= key_pins;
      key_s2_ff <= key_s1_ff;
      key_d_ff  <= key_s2_ff;
      dig_ff    <= {dig_ff[1:0], digit_pin};
    end
  end

  wire [`FPKL_NKEYS-1:0] key_press = key_s2_ff & ~key_d_ff;
  wire                   any_press = |key_press;
  wire                   digit_press = dig_ff[1] & ~dig_ff[2];
  wire p_normal_mode_indicator = key_press[`FPKL_KEY_NORMAL];
  wire p_dial = key_press[`FPKL_KEY_DIAL];
  wire p_arm  = key_press[`FPKL_KEY_ARM];
  wire p_pwr  = key_press[`FPKL_KEY_POWER];
  wire p_prog = key_press[`FPKL_KEY_PROGRAM];
  wire p_ent  = key_press[`FPKL_KEY_ENTER];
  wire p_can  = key_press[`FPKL_KEY_CANCEL];
  wire h_dial = key_s2_ff[`FPKL_KEY_DIAL];
  wire h_rec  = key_s2_ff[`FPKL_KEY_RECORD];

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  fpkl_pkg::fpkl_mode_t mode_ff;
  fpkl_pkg::fpkl_mode_t nxt_mode;
  logic                 unit_on_ff;
  logic                 disarmed_ff;
  logic                 rec_en_ff;
  logic                 connected_dial_ff;
  logic [`FPKL_TB_W-1:0] tb_ff;

  // Mode changes; keys change the mode only while the unit is on
  always_comb begin
    nxt_mode = mode_ff;
    if (unit_on_ff) begin
      if (p_normal_mode_indicator) begin
        nxt_mode = (mode_ff == fpkl_pkg::FPKL_NORMAL) ?
                   fpkl_pkg::FPKL_CHECK : fpkl_pkg::FPKL_NORMAL;
      end else if (p_prog) begin
        nxt_mode = fpkl_pkg::FPKL_PROG;
      end else if (p_dial && mode_ff != fpkl_pkg::FPKL_DIAL) begin
        nxt_mode = fpkl_pkg::FPKL_DIAL;
      end else if (mode_ff == fpkl_pkg::FPKL_CHECK && status_in.report_done) begin
        nxt_mode = fpkl_pkg::FPKL_NORMAL;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode_ff           <= fpkl_pkg::FPKL_NORMAL;
      unit_on_ff        <= 1'b1;
      disarmed_ff       <= 1'b0;
      connected_dial_ff <= 1'b0;
      tb_ff             <= '0;
    end else if (clk_en) begin
      tb_ff   <= tb_ff + 1'b1;
      mode_ff <= nxt_mode;
      if (p_pwr) begin
        unit_on_ff <= ~unit_on_ff;
      end
      if (p_arm && unit_on_ff) begin
        disarmed_ff <= ~disarmed_ff;
      end
      if (p_dial && mode_ff != fpkl_pkg::FPKL_DIAL) begin
        connected_dial_ff <= status_in.call_connected;
      end
    end
  end

  // ------------------------------------------------------------
  // Command outputs, registered
  // ------------------------------------------------------------
  wire dialing  = mode_ff == fpkl_pkg::FPKL_DIAL;
  wire in_prog  = mode_ff == fpkl_pkg::FPKL_PROG;
  fpkl_pkg::fpkl_cmd_t nxt_cmd;

  always_comb begin
    nxt_cmd                    = '0;
    nxt_cmd.end_calls          = unit_on_ff & p_normal_mode_indicator;
    nxt_cmd.start_check_report = unit_on_ff & p_normal_mode_indicator & (mode_ff == fpkl_pkg::FPKL_NORMAL);
    nxt_cmd.seize_line         = unit_on_ff & p_dial & ~dialing
                                 & ~status_in.call_connected;
    nxt_cmd.suspend_report     = unit_on_ff & p_dial & ~dialing
                                 & status_in.call_connected;
    nxt_cmd.dial_digit         = dialing & digit_press & ~connected_dial_ff;
    nxt_cmd.talk               = dialing & h_dial & ~p_dial;
    nxt_cmd.execute_code       = in_prog & p_ent;
    nxt_cmd.cancel_code        = in_prog & p_can;
    nxt_cmd.ack_alarms         = any_press & alarm_unacked;
    nxt_cmd.clear_old_alarms   = unit_on_ff & p_arm & disarmed_ff;
  end

  // ------------------------------------------------------------
  // LED drive
  // ------------------------------------------------------------
  wire pf        = status_in.primary_power_fail;
  wire blink_n   = pf ? tb_ff[`FPKL_TB_FAST] : tb_ff[`FPKL_TB_NORMAL_MODE_INDICATOR];
  wire blink_f   = tb_ff[`FPKL_TB_FAST];
  wire blink_s   = pf ? tb_ff[`FPKL_TB_FAST] : tb_ff[`FPKL_TB_SLOW];
  // Steady LEDs flash on battery to save power
  wire steady    = pf ? tb_ff[`FPKL_TB_FAST] : 1'b1;
  wire recording = h_rec & rec_en_ff & unit_on_ff;

  fpkl_pkg::fpkl_leds_t nxt_leds;
  logic [NCHAN-1:0]     nxt_chan;

  always_comb begin
    nxt_leds = '0;
    nxt_leds.normal_mode_indicator = steady & (mode_ff == fpkl_pkg::FPKL_NORMAL);
    nxt_leds.check_indicator       = steady & (mode_ff == fpkl_pkg::FPKL_CHECK);
    nxt_leds.low_battery_indicator = steady & status_in.battery_below_threshold;
    nxt_leds.power_fail_indicator  = steady & pf;
    nxt_leds.telephone_failure_indicator = blink_f & status_in.telephone_failure_indicator_unacked;
    nxt_leds.net_plc_indicator     = status_in.scan_on &
      (status_in.net_comm_alarm ? blink_n : steady);
    nxt_leds.net_printer_indicator = status_in.printer_enabled &
      (status_in.printer_flow_ctl ? blink_n : steady);
    nxt_leds.net_aware_indicator   = steady & status_in.aware_session;
    nxt_leds.net_log_indicator     = status_in.log_enabled &
      (status_in.log_losing ? blink_n : steady);
    nxt_leds.program_indicator     = steady & (in_prog | status_in.prog_remote);
    nxt_leds.recording_indicator   = steady & recording;
    nxt_leds.disarmed_indicator    = blink_n & disarmed_ff;
    nxt_leds.line_activity_indicator = status_in.off_hook ? steady :
      (status_in.intersession_delay & blink_s);
    if (!unit_on_ff) begin
      nxt_leds = '0;
    end
  end

  // Channel LEDs share blink_n so all unacked alarms flash in step
  genvar gi;
  generate
    for (gi = 0; gi < NCHAN; gi++) begin : g_chan
      assign nxt_chan[gi] = unit_on_ff & chan_alarm[gi] &
                            (chan_acked[gi] ? steady : blink_n);
    end
  endgenerate

  // ------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------
  wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
  wire sel_ctrl = wb_adr_i == `FPKL_REG_CTRL;
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0;
    unique case (wb_adr_i)
      `FPKL_REG_CTRL:   rd_mux = {31'h0, rec_en_ff};
      `FPKL_REG_STATUS: rd_mux = {25'h0, recording, disarmed_ff, unit_on_ff,
                                  connected_dial_ff, dialing, mode_ff};
      `FPKL_REG_KEYS:   rd_mux = {24'h0, key_s2_ff};
      `FPKL_REG_CHAN:   rd_mux = 32'(chan_alarm);
      default:          rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0;
      rec_en_ff   <= 1'b0;
      leds_o      <= '0;
      chan_led_o  <= '0;
      cmd_o       <= '0;
      unit_on_o   <= 1'b1;
      disarmed_o  <= 1'b0;
      recording_o <= 1'b0;
      mode_o      <= fpkl_pkg::FPKL_NORMAL;
    end else if (clk_en) begin
      wb_ack_o    <= wb_req;
      wb_dat_o    <= wb_req ? rd_mux : 32'h0;
      if (wb_wr && sel_ctrl && wb_sel_i[0]) begin
        rec_en_ff <= wb_dat_i[`FPKL_CTRL_REC_EN];
      end
      leds_o      <= nxt_leds;
      chan_led_o  <= nxt_chan;
      cmd_o       <= nxt_cmd;
      unit_on_o   <= unit_on_ff;
      disarmed_o  <= disarmed_ff;
      recording_o <= recording;
      mode_o      <= mode_ff;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_normal_mode_indicator_key;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && unit_on_ff && p_normal_mode_indicator && mode_ff != fpkl_pkg::FPKL_NORMAL
      |=> mode_ff == fpkl_pkg::FPKL_NORMAL;
  endproperty
  a_normal_mode_indicator_key: assert property (p_normal_mode_indicator_key) else $error("normal key missed");

  property p_check;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && unit_on_ff && p_normal_mode_indicator && mode_ff == fpkl_pkg::FPKL_NORMAL
      |=> cmd_o.start_check_report && mode_ff == fpkl_pkg::FPKL_CHECK;
  endproperty
  a_check: assert property (p_check) else $error("check report missing");

  property p_power;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && p_pwr |=> unit_on_ff != $past(unit_on_ff);
  endproperty
  a_power: assert property (p_power) else $error("power toggle failed");

  property p_arm_toggle;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && unit_on_ff && p_arm && disarmed_ff
      |=> !disarmed_ff && cmd_o.clear_old_alarms;
  endproperty
  a_arm_toggle: assert property (p_arm_toggle) else $error("re-arm failed");

  property p_ack;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && any_press && alarm_unacked |=> cmd_o.ack_alarms;
  endproperty
  a_ack: assert property (p_ack) else $error("alarm not acknowledged");

  property p_rec;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && !rec_en_ff |=> !recording_o;
  endproperty
  a_rec: assert property (p_rec) else $error("recording while not enabled");

  property p_suspend;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && unit_on_ff && p_dial && !dialing && status_in.call_connected
      |=> cmd_o.suspend_report && !cmd_o.seize_line;
  endproperty
  a_suspend: assert property (p_suspend) else $error("redial on connected call");

  property p_telephone_failure_indicator;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && !status_in.telephone_failure_indicator_unacked |=> !leds_o.telephone_failure_indicator;
  endproperty
  a_telephone_failure_indicator: assert property (p_telephone_failure_indicator) else $error("telephone_failure_indicator led lit");

  property p_prog_key;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && unit_on_ff && p_prog && !p_normal_mode_indicator |=> mode_ff == fpkl_pkg::FPKL_PROG;
  endproperty
  a_prog_key: assert property (p_prog_key) else $error("program key missed");

  property p_dial_seize;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && unit_on_ff && p_dial && !p_normal_mode_indicator && !p_prog && !dialing
      && !status_in.call_connected
      |=> cmd_o.seize_line && mode_ff == fpkl_pkg::FPKL_DIAL;
  endproperty
  a_dial_seize: assert property (p_dial_seize) else $error("line not seized");

  property p_no_redial;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && connected_dial_ff |=> !cmd_o.dial_digit;
  endproperty
  a_no_redial: assert property (p_no_redial) else $error("joined call redialed");

  property p_mode_leds;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && unit_on_ff && !status_in.primary_power_fail
      |=> leds_o.normal_mode_indicator == (mode_o == fpkl_pkg::FPKL_NORMAL)
          && leds_o.check_indicator == (mode_o == fpkl_pkg::FPKL_CHECK);
  endproperty
  a_mode_leds: assert property (p_mode_leds) else $error("mode leds wrong");

  property p_low_battery_indicator;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && unit_on_ff && !status_in.primary_power_fail
      |=> leds_o.low_battery_indicator == $past(status_in.battery_below_threshold);
  endproperty
  a_low_battery_indicator: assert property (p_low_battery_indicator) else $error("low battery led wrong");

  property p_pf_dark;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && status_in.primary_power_fail && !tb_ff[`FPKL_TB_FAST]
      |=> leds_o == '0 && chan_led_o == '0;
  endproperty
  a_pf_dark: assert property (p_pf_dark) else $error("led lit in dark phase");

  property p_off_dark;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && !unit_on_ff |=> leds_o == '0 && chan_led_o == '0;
  endproperty
  a_off_dark: assert property (p_off_dark) else $error("led lit while off");

  property p_chan_ack;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && unit_on_ff && !status_in.primary_power_fail
      |=> (chan_led_o & $past(chan_acked)) == $past(chan_alarm & chan_acked);
  endproperty
  a_chan_ack: assert property (p_chan_ack) else $error("acked channel not steady");

  wire [NCHAN-1:0] chan_blinking = chan_alarm & ~chan_acked;

  property p_chan_sync;
    @(posedge sys_clk) disable iff (!nrst)
      clk_en && unit_on_ff
      |=> (chan_led_o & $past(chan_blinking)) == '0
          || (chan_led_o & $past(chan_blinking)) == $past(chan_blinking);
  endproperty
  a_chan_sync: assert property (p_chan_sync) else $error("channel blink out of step");

endmodule

// ### rtl/fpkl_map.svh
// Purpose: Constants for the front panel key and LED controller
// Assumes: 200 MHz sys_clk, Wishbone register offsets are byte addresses
// Notes:   Included by the top module, the operator model and the bench
`ifndef FPKL_MAP_SVH
`define FPKL_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define FPKL_REG_CTRL    4'h0
`define FPKL_REG_STATUS  4'h4
`define FPKL_REG_KEYS    4'h8
`define FPKL_REG_CHAN    4'hC

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define FPKL_CTRL_REC_EN   0
`define FPKL_CTRL_CLR_ALM  1

// ------------------------------------------------------------
// Key indices
// ------------------------------------------------------------
`define FPKL_KEY_NORMAL    0
`define FPKL_KEY_DIAL      1
`define FPKL_KEY_ARM       2
`define FPKL_KEY_POWER     3
`define FPKL_KEY_PROGRAM   4
`define FPKL_KEY_ENTER     5
`define FPKL_KEY_CANCEL    6
`define FPKL_KEY_RECORD    7
`define FPKL_NKEYS         8

// ------------------------------------------------------------
// Blink timebase bits (200 MHz: bit 26 ~1.5 Hz, 25 ~3 Hz, 24 ~6 Hz)
// ------------------------------------------------------------
`define FPKL_TB_W          27
`define FPKL_TB_SLOW       26
`define FPKL_TB_NORMAL_MODE_INDICATOR       25
`define FPKL_TB_FAST       24

`endif

// ### rtl/fpkl_pkg.sv
// Purpose: Types for the front panel key and LED controller
// Assumes: Constants come from fpkl_map.svh
// Notes:   Nothing here is imported; use fpkl_pkg::name
package fpkl_pkg;

  // Unit operating mode, Gray coded along normal-check-program
  typedef enum logic [1:0] {
    FPKL_NORMAL = 2'b00,
    FPKL_CHECK  = 2'b01,
    FPKL_PROG   = 2'b11,
    FPKL_DIAL   = 2'b10
  } fpkl_mode_t;

  // Status from the rest of the unit
  typedef struct packed {
    logic battery_below_threshold;
    logic primary_power_fail;
    logic telephone_failure_indicator_unacked;
    logic scan_on;
    logic net_comm_alarm;
    logic printer_enabled;
    logic printer_flow_ctl;
    logic aware_session;
    logic log_enabled;
    logic log_losing;
    logic prog_remote;
    logic off_hook;
    logic intersession_delay;
    logic call_connected;
    logic report_done;
  } fpkl_status_t;

  // Panel LEDs
  typedef struct packed {
    logic normal_mode_indicator;
    logic check_indicator;
    logic low_battery_indicator;
    logic power_fail_indicator;
    logic telephone_failure_indicator;
    logic net_plc_indicator;
    logic net_printer_indicator;
    logic net_aware_indicator;
    logic net_log_indicator;
    logic program_indicator;
    logic recording_indicator;
    logic disarmed_indicator;
    logic line_activity_indicator;
  } fpkl_leds_t;

  // Commands issued to the rest of the unit
  typedef struct packed {
    logic end_calls;
    logic start_check_report;
    logic seize_line;
    logic dial_digit;
    logic talk;
    logic suspend_report;
    logic execute_code;
    logic cancel_code;
    logic ack_alarms;
    logic clear_old_alarms;
  } fpkl_cmd_t;

endpackage

// ### verification/fpkl_operator.sv
// Purpose: Operator at the panel keys and the digit keypad
// Assumes: Key lines are plain levels, low while not pressed
// Notes:   Changes lines only just after a rising edge
`timescale 1ns/100ps
`include "fpkl_map.svh"

module fpkl_operator (
  input  wire logic                   sys_clk,
  output logic [`FPKL_NKEYS-1:0]      key_pins,
  output logic                        digit_pin
);
  initial begin
    key_pins = '0;
    digit_pin = 1'b0;
  end

  // Six edges cover the two-stage sync plus decode
  task automatic hold(input int k);
    @(posedge sys_clk);
    key_pins[k] <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic rel(input int k);
    key_pins[k] <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic press(input int k);
    hold(k);
    rel(k);
  endtask

  task automatic digit();
    @(posedge sys_clk);
    digit_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    digit_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

// ### verification/fpkl_top_tb.sv
// Purpose: Self-checking bench for the panel key and LED logic
// Assumes: Blink bits stay low 2^24 cycles after reset; only dark phase seen
// Notes:   Command pulses are caught in a sticky copy
`timescale 1ns/100ps
`include "fpkl_map.svh"

module fpkl_top_tb;
  logic                   sys_clk, nrst, clk_en, digit_pin, alarm_unacked, clr_seen;
  logic                   wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic                   unit_on_o, disarmed_o, recording_o;
  logic [3:0]             wb_adr_i, wb_sel_i;
  logic [31:0]            wb_dat_i, wb_dat_o, rd;
  logic [7:0]             key_pins, chan_alarm, chan_acked, chan_led_o;
  fpkl_pkg::fpkl_status_t st;
  fpkl_pkg::fpkl_leds_t   leds_o;
  fpkl_pkg::fpkl_cmd_t    cmd_o, seen;
  fpkl_pkg::fpkl_mode_t   mode_o;
  int                     n_errors, samples_checked;

  fpkl_top #(.NCHAN(8)) uut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
    .key_pins(key_pins), .digit_pin(digit_pin), .status_in(st), .chan_alarm(chan_alarm),
    .chan_acked(chan_acked), .alarm_unacked(alarm_unacked), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .leds_o(leds_o),
    .chan_led_o(chan_led_o), .cmd_o(cmd_o), .unit_on_o(unit_on_o),
    .disarmed_o(disarmed_o), .recording_o(recording_o), .mode_o(mode_o));

  fpkl_operator op (.sys_clk(sys_clk), .key_pins(key_pins), .digit_pin(digit_pin));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    seen <= clr_seen ? '0 : (seen | cmd_o);
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i >= 20) begin
      chk(1'b0, 1'b1, "bus timeout");
      print_verdict();
    end
  endtask

  task automatic clr();
    clr_seen <= 1'b1;
    @(posedge sys_clk);
    clr_seen <= 1'b0;
  endtask

  task automatic act(input int k);
    clr();
    op.press(k);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i, alarm_unacked} = '0;
    {wb_adr_i, wb_dat_i, chan_alarm, chan_acked} = '0;
    wb_sel_i = 4'hF;
    clk_en = 1'b1;
    st = '0;
    clr_seen = 1'b1;
    n_errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    clr_seen <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(unit_on_o, 1'b1, "on after reset");
    chk(leds_o.normal_mode_indicator, 1'b1, "normal led");
    wb(1'b0, `FPKL_REG_STATUS, 32'h0);
    chk(rd, 32'h10, "status word");
    wb(1'b0, 4'h1, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    wb(1'b1, `FPKL_REG_CTRL, 32'h1);
    wb(1'b0, `FPKL_REG_CTRL, 32'h0);
    chk(rd, 32'h1, "record enable");
    act(`FPKL_KEY_NORMAL);
    chk(mode_o, fpkl_pkg::FPKL_CHECK, "check mode");
    chk({seen.start_check_report, seen.end_calls}, 2'b11, "report cmds");
    chk({leds_o.normal_mode_indicator, leds_o.check_indicator}, 2'b01, "check leds");
    st.report_done <= 1'b1;
    @(posedge sys_clk);
    st.report_done <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(mode_o, fpkl_pkg::FPKL_NORMAL, "back to normal");
    act(`FPKL_KEY_ENTER);
    chk(seen.execute_code, 1'b0, "enter outside program");
    act(`FPKL_KEY_PROGRAM);
    chk(mode_o, fpkl_pkg::FPKL_PROG, "program mode");
    chk(leds_o.program_indicator, 1'b1, "program led");
    act(`FPKL_KEY_ENTER);
    chk(seen.execute_code, 1'b1, "execute");
    act(`FPKL_KEY_CANCEL);
    chk(seen.cancel_code, 1'b1, "cancel");
    act(`FPKL_KEY_NORMAL);
    st.prog_remote <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(leds_o.program_indicator, 1'b1, "remote program led");
    st.prog_remote <= 1'b0;
    act(`FPKL_KEY_ARM);
    chk(disarmed_o, 1'b1, "disarm");
    act(`FPKL_KEY_ARM);
    chk({disarmed_o, seen.clear_old_alarms}, 2'b01, "re-arm clears");
    alarm_unacked <= 1'b1;
    act(`FPKL_KEY_CANCEL);
    chk(seen.ack_alarms, 1'b1, "any key acks");
    alarm_unacked <= 1'b0;
    op.hold(`FPKL_KEY_RECORD);
    chk({recording_o, leds_o.recording_indicator}, 2'b11, "recording");
    op.rel(`FPKL_KEY_RECORD);
    chk({recording_o, leds_o.recording_indicator}, 2'b00, "record released");
    wb(1'b1, `FPKL_REG_CTRL, 32'h0);
    op.hold(`FPKL_KEY_RECORD);
    chk(recording_o, 1'b0, "record not enabled");
    op.rel(`FPKL_KEY_RECORD);
    act(`FPKL_KEY_DIAL);
    chk(seen.seize_line, 1'b1, "seize line");
    clr();
    op.digit();
    chk(seen.dial_digit, 1'b1, "digit dialed");
    op.hold(`FPKL_KEY_DIAL);
    chk(cmd_o.talk, 1'b1, "talk while held");
    op.rel(`FPKL_KEY_DIAL);
    chk(cmd_o.talk, 1'b0, "listen on release");
    act(`FPKL_KEY_NORMAL);
    chk(mode_o, fpkl_pkg::FPKL_NORMAL, "call ended");
    st.call_connected <= 1'b1;
    act(`FPKL_KEY_DIAL);
    chk({seen.suspend_report, seen.seize_line}, 2'b10, "join call");
    clr();
    op.digit();
    chk(seen.dial_digit, 1'b0, "no redial");
    act(`FPKL_KEY_NORMAL);
    st.call_connected <= 1'b0;
    act(`FPKL_KEY_POWER);
    chk(unit_on_o, 1'b0, "power off");
    act(`FPKL_KEY_ARM);
    chk(disarmed_o, 1'b0, "keys ignored while off");
    chk({leds_o, chan_led_o}, 32'h0, "dark while off");
    act(`FPKL_KEY_POWER);
    chk(unit_on_o, 1'b1, "power on");
    st.battery_below_threshold <= 1'b1;
    st.scan_on <= 1'b1;
    st.printer_enabled <= 1'b1;
    st.log_enabled <= 1'b1;
    st.off_hook <= 1'b1;
    chan_alarm <= 8'h81;
    chan_acked <= 8'h81;
    repeat (4) @(posedge sys_clk);
    chk(leds_o.low_battery_indicator, 1'b1, "low battery");
    chk(leds_o.net_plc_indicator, 1'b1, "plc scan");
    chk(leds_o.net_printer_indicator, 1'b1, "printer");
    chk(leds_o.net_log_indicator, 1'b1, "log");
    chk(leds_o.line_activity_indicator, 1'b1, "off hook");
    chk(leds_o.telephone_failure_indicator, 1'b0, "no tel fail");
    chk(chan_led_o, 8'h81, "acked channels steady");
    chan_acked <= 8'h01;
    st.telephone_failure_indicator_unacked <= 1'b1;
    st.net_comm_alarm <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(chan_led_o, 8'h01, "alarmed channel blinks");
    chk(leds_o.telephone_failure_indicator, 1'b0, "tel fail blinks");
    chk(leds_o.net_plc_indicator, 1'b0, "plc comm alarm blinks");
    st.primary_power_fail <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({leds_o, chan_led_o}, 32'h0, "power fail blinks all");
    st.primary_power_fail <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(leds_o.low_battery_indicator, 1'b1, "blink stops on power");
    print_verdict();
  end
endmodule
